// file: rtl/arp_params.svh
// Purpose: offsets, field positions, reset values and timing counts of the result port
// Assumes: included by bare name after the package
// Notes:   times are in ns, cycle counts derive from the 5 ns mclk period
`ifndef ARP_PARAMS_SVH
`define ARP_PARAMS_SVH

`define ARP_OFS_CTRL        12'h000
`define ARP_OFS_STAT        12'h004
`define ARP_OFS_RESULT      12'h008

`define ARP_CTRL_PORT_BIT   0
`define ARP_CTRL_SWAP_BIT   1
`define ARP_CTRL_CODING_BIT 2
`define ARP_CTRL_RESET      3'h0

`define ARP_STAT_MODE_LSB   0
`define ARP_STAT_DIV_LSB    2
`define ARP_STAT_SRC_BIT    4
`define ARP_STAT_POL_BIT    5
`define ARP_STAT_RDT_BIT    6
`define ARP_STAT_BUSY_BIT   7

`define ARP_RESP_OKAY       2'h0
`define ARP_RESP_SLVERR     2'h2

`define ARP_DIV_PIN_LSB     2
`define ARP_SRC_PIN         4
`define ARP_POL_PIN         5
`define ARP_RDT_PIN         7
`define ARP_SERIAL_RESULT_OUT_LANE      8

`define ARP_SER_BITS        16
`define ARP_MCLK_NS         5
`define ARP_SCLK_NS_00      25
`define ARP_SCLK_NS_01      50
`define ARP_SCLK_NS_10      100
`define ARP_SCLK_NS_11      200
`define ARP_LEAD_NS         20
`define ARP_CYC(ns)         (((ns) + `ARP_MCLK_NS - 1) / `ARP_MCLK_NS)

`endif

// file: rtl/arp_pkg.sv
// Purpose: types shared by the result port files
// Assumes: nothing
// Notes:   constants live in arp_params.svh
package arp_pkg;

    typedef enum logic [1:0] {
        ARP_MODE_PAR     = 2'b00,
        ARP_MODE_MST_RDC = 2'b01,
        ARP_MODE_MST_RDD = 2'b10,
        ARP_MODE_SLV     = 2'b11
    } arp_mode_type;

    typedef enum logic [1:0] {
        ARP_SER_IDLE = 2'b00,
        ARP_SER_LEAD = 2'b01,
        ARP_SER_HIGH = 2'b10,
        ARP_SER_LOW  = 2'b11
    } arp_ser_state_type;

    typedef struct packed {
        logic output_coding_select;
        logic byte_order_select;
        logic port_type_select;
    } arp_ctrl_type;

    typedef struct packed {
        logic       read_timing_select;
        logic       frame_strobe_polarity_select;
        logic       clock_source_select;
        logic [1:0] serial_clock_divider_select;
    } arp_scfg_type;

    typedef struct packed {
        logic [15:0] d_out;
        logic [15:0] d_oe;
        logic        sclk_o;
        logic        sclk_oe;
        logic        strobe_o;
        logic        strobe_oe;
    } arp_pins_type;

    typedef struct packed {
        arp_ser_state_type st;
        logic [15:0]       sh;
        logic [7:0]        cnt;
        logic [4:0]        left;
        logic              sclk;
        logic              bit_out;
        logic              frame;
        logic              sclk_q;
    } arp_ser_st_type;

endpackage : arp_pkg

// file: rtl/arp_fmt.sv
// Purpose: output coding and byte lane order of one result word
// Assumes: width is even
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
module arp_fmt
    import arp_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic [W-1:0] raw,
    input  wire logic         output_coding_select,
    input  wire logic         byte_order_select,
    output logic      [W-1:0] coded,
    output logic      [W-1:0] lanes
);
    always_comb begin
        // low select flips the msb to give two's complement
        coded = {raw[W-1] ^ ~output_coding_select, raw[W-2:0]}; // RL2
        if (byte_order_select) begin
            lanes = {coded[W/2-1:0], coded[W-1:W/2]}; // RL1
        end else begin
            lanes = coded; // RL1
        end
    end
endmodule : arp_fmt
`default_nettype wire

// file: rtl/arp_ser.sv
// Purpose: serial result shifter, master clock generator or slave clock follower
// Assumes: sclk_in and cs_n are synchronous to mclk
// Notes:   msb first; slave advances on rising sclk only while cs_n is low
`timescale 1ns/10ps
`default_nettype none
`include "arp_params.svh"
module arp_ser
    import arp_pkg::*;
#(
    parameter int BITS = `ARP_SER_BITS
) (
    input  wire logic            mclk,
    input  wire logic            rst_n,
    input  wire logic            master,
    input  wire logic [1:0]      div_code,
    input  wire logic            start,
    input  wire logic [BITS-1:0] data,
    input  wire logic            cs_n,
    input  wire logic            sclk_in,
    output logic                 sclk,
    output logic                 bit_out,
    output logic                 frame,
    output logic                 busy
);
    arp_ser_st_type st_r;
    arp_ser_st_type st_nxt;
    logic [7:0]     per;
    logic [7:0]     hi;
    logic [7:0]     lo;

    always_comb begin
        case (div_code)
            2'b00:   per = 8'(`ARP_CYC(`ARP_SCLK_NS_00)); // RL12
            2'b01:   per = 8'(`ARP_CYC(`ARP_SCLK_NS_01)); // RL12
            2'b10:   per = 8'(`ARP_CYC(`ARP_SCLK_NS_10)); // RL12
            default: per = 8'(`ARP_CYC(`ARP_SCLK_NS_11)); // RL12
        endcase
        hi = 8'((per + 8'h01) >> 1);
        lo = 8'(per >> 1);
        st_nxt = st_r;
        st_nxt.sclk_q = sclk_in;
        case (st_r.st)
            ARP_SER_IDLE: begin
                if (start && st_r.left == 5'h00) begin
                    st_nxt.sh = data;
                    st_nxt.bit_out = data[BITS-1];
                    st_nxt.left = 5'(BITS);
                    if (master) begin // RL8
                        st_nxt.frame = 1'b1;
                        st_nxt.cnt = 8'(`ARP_CYC(`ARP_LEAD_NS) - 1);
                        st_nxt.st = ARP_SER_LEAD;
                    end
                end else if (!master && st_r.left != 5'h00 && !cs_n
                             && sclk_in && !st_r.sclk_q) begin // RL9 RL10
                    st_nxt.sh = st_r.sh << 1;
                    st_nxt.bit_out = st_r.sh[BITS-2];
                    st_nxt.left = st_r.left - 5'h01;
                end
            end
            ARP_SER_LEAD: begin
                if (st_r.cnt == 8'h00) begin
                    st_nxt.st = ARP_SER_HIGH;
                    st_nxt.sclk = 1'b1;
                    st_nxt.cnt = hi - 8'h01;
                end else begin
                    st_nxt.cnt = st_r.cnt - 8'h01;
                end
            end
            ARP_SER_HIGH: begin
                if (st_r.cnt == 8'h00) begin
                    st_nxt.st = ARP_SER_LOW;
                    st_nxt.sclk = 1'b0;
                    st_nxt.cnt = lo - 8'h01;
                end else begin
                    st_nxt.cnt = st_r.cnt - 8'h01;
                end
            end
            ARP_SER_LOW: begin
                if (st_r.cnt != 8'h00) begin
                    st_nxt.cnt = st_r.cnt - 8'h01;
                end else if (st_r.left == 5'h01) begin
                    st_nxt.st = ARP_SER_IDLE;
                    st_nxt.frame = 1'b0;
                    st_nxt.left = 5'h00;
                end else begin
                    st_nxt.sh = st_r.sh << 1;
                    st_nxt.bit_out = st_r.sh[BITS-2];
                    st_nxt.left = st_r.left - 5'h01;
                    st_nxt.st = ARP_SER_HIGH;
                    st_nxt.sclk = 1'b1;
                    st_nxt.cnt = hi - 8'h01;
                end
            end
            default: st_nxt = '0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sclk    = st_r.sclk;
    assign bit_out = st_r.bit_out;
    assign frame   = st_r.frame;
    assign busy    = (st_r.left != 5'h00);
endmodule : arp_ser
`default_nettype wire

// file: rtl/arp_top.sv
// Purpose: result port mode selection, pin sharing and AXI4-Lite registers
// Assumes: converter core pulses conv_start and conv_done; pins synchronous to mclk
// Notes:   serial selects are taken from the shared data pins while serial is on
//
// Notes on behaviour
// RL1: byte order low puts low byte on D[7:0]; high swaps the lanes.
// RL2: coding high gives straight binary; low inverts msb for two's complement.
// RL3: port type low runs the parallel port; high switches to serial pins.
// RL4: D[0] and D[1] float in serial mode; carry result bits only in parallel.
// RL5: in parallel mode D[2] to D[5] drive result bits, never act as inputs.
// RL6: divider pins are inputs only in master read-after-conversion mode.
// RL7: divider pins float in every other serial mode.
// RL8: clock source low in serial mode makes device master driving sclk.
// RL9: clock source high makes device slave; data follows the external sclk.
// RL10: slave honours sclk edges only while chip select is low.
// RL11: frame strobe active high when polarity low, active low when high.
// RL12: divider codes 00 to 11 set sclk period 25, 50, 100, 200 ns.
// RL13: read timing low shifts after conversion; high shifts previous result during.
// RL14: the host keeps all selects steady during a read sequence.
`timescale 1ns/10ps
`default_nettype none
`include "arp_params.svh"
module arp_top
    import arp_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int BITS   = `ARP_SER_BITS
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              conv_start,
    input  wire logic              conv_done,
    input  wire logic [BITS-1:0]   conv_data,
    input  wire logic [15:0]       d_in,
    input  wire logic              cs_n,
    input  wire logic              sclk_i,
    output arp_pins_type           pins_o
);
    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              aw_held;
        logic              w_held;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        arp_ctrl_type      ctrl;
        arp_scfg_type      scfg;
        arp_mode_type      mode;
        logic [BITS-1:0]   raw;
        logic              done_q;
        arp_pins_type      pins;
        logic [7:0]        chk_hi;
    } arp_top_st_type;

    arp_top_st_type  st_r;
    arp_top_st_type  st_nxt;
    logic [BITS-1:0] coded;
    logic [BITS-1:0] lanes;
    logic [1:0]      used_div;
    logic            ser_start;
    logic            ser_sclk;
    logic            ser_bit;
    logic            ser_frame;
    logic            ser_busy;
    logic [31:0]     stat_word;
    logic [7:0]      exp_hi;

    arp_fmt #(.W(BITS)) u_fmt (
        .raw                  (st_r.raw),
        .output_coding_select (st_r.ctrl.output_coding_select),
        .byte_order_select    (st_r.ctrl.byte_order_select),
        .coded                (coded),
        .lanes                (lanes)
    );

    arp_ser #(.BITS(BITS)) u_ser (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .master   (st_r.mode != ARP_MODE_SLV),
        .div_code (used_div),
        .start    (ser_start),
        .data     (coded),
        .cs_n     (cs_n),
        .sclk_in  (sclk_i),
        .sclk     (ser_sclk),
        .bit_out  (ser_bit),
        .frame    (ser_frame),
        .busy     (ser_busy)
    );

    always_comb begin
        // the divider only slows the clock in master read-after-conversion
        used_div = (st_r.mode == ARP_MODE_MST_RDC)
                 ? st_r.scfg.serial_clock_divider_select : 2'b00; // RL6
        case (st_r.mode)
            ARP_MODE_MST_RDC: ser_start = st_r.done_q;  // RL13
            ARP_MODE_MST_RDD: ser_start = conv_start;   // RL13
            ARP_MODE_SLV:     ser_start = st_r.done_q;
            default:          ser_start = 1'b0;
        endcase
        stat_word = 32'h0000_0000;
        stat_word[`ARP_STAT_MODE_LSB +: 2] = st_r.mode;
        stat_word[`ARP_STAT_DIV_LSB +: 2]  = st_r.scfg.serial_clock_divider_select;
        stat_word[`ARP_STAT_SRC_BIT]       = st_r.scfg.clock_source_select;
        stat_word[`ARP_STAT_POL_BIT]       = st_r.scfg.frame_strobe_polarity_select;
        stat_word[`ARP_STAT_RDT_BIT]       = st_r.scfg.read_timing_select;
        stat_word[`ARP_STAT_BUSY_BIT]      = ser_busy;
    end

    always_comb begin
        st_nxt = st_r;
        // result capture
        st_nxt.done_q = conv_done;
        if (conv_done) begin
            st_nxt.raw = conv_data;
        end
        // write channel
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.awready = 1'b0;
            st_nxt.aw_held = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.wready = 1'b0;
            st_nxt.w_held = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = `ARP_RESP_OKAY;
            if (st_r.awaddr == ADDR_W'(`ARP_OFS_CTRL)) begin
                if (st_r.wstrb[0]) begin
                    st_nxt.ctrl.port_type_select = st_r.wdata[`ARP_CTRL_PORT_BIT];
                    st_nxt.ctrl.byte_order_select = st_r.wdata[`ARP_CTRL_SWAP_BIT];
                    st_nxt.ctrl.output_coding_select = st_r.wdata[`ARP_CTRL_CODING_BIT];
                end
            end else if (st_r.awaddr != ADDR_W'(`ARP_OFS_STAT)
                         && st_r.awaddr != ADDR_W'(`ARP_OFS_RESULT)) begin
                st_nxt.bresp = `ARP_RESP_SLVERR;
            end
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
            st_nxt.awready = 1'b1;
            st_nxt.wready = 1'b1;
        end
        // read channel
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.arready = 1'b0;
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = `ARP_RESP_OKAY;
            if (s_axi_araddr == ADDR_W'(`ARP_OFS_CTRL)) begin
                st_nxt.rdata = 32'h0000_0000;
                st_nxt.rdata[`ARP_CTRL_PORT_BIT] = st_r.ctrl.port_type_select;
                st_nxt.rdata[`ARP_CTRL_SWAP_BIT] = st_r.ctrl.byte_order_select;
                st_nxt.rdata[`ARP_CTRL_CODING_BIT] = st_r.ctrl.output_coding_select;
            end else if (s_axi_araddr == ADDR_W'(`ARP_OFS_STAT)) begin
                st_nxt.rdata = stat_word;
            end else if (s_axi_araddr == ADDR_W'(`ARP_OFS_RESULT)) begin
                st_nxt.rdata = {16'h0000, coded};
            end else begin
                st_nxt.rdata = 32'h0000_0000;
                st_nxt.rresp = `ARP_RESP_SLVERR;
            end
        end
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
            st_nxt.arready = 1'b1;
        end
        // shared pins act as serial selects only while serial is on
        if (st_r.ctrl.port_type_select) begin // RL3
            st_nxt.scfg.serial_clock_divider_select = d_in[`ARP_DIV_PIN_LSB +: 2]; // RL6
            st_nxt.scfg.clock_source_select = d_in[`ARP_SRC_PIN];
            st_nxt.scfg.frame_strobe_polarity_select = d_in[`ARP_POL_PIN];
            st_nxt.scfg.read_timing_select = d_in[`ARP_RDT_PIN];
        end
        if (!st_r.ctrl.port_type_select) begin
            st_nxt.mode = ARP_MODE_PAR; // RL3
        end else if (st_r.scfg.clock_source_select) begin
            st_nxt.mode = ARP_MODE_SLV; // RL9
        end else if (st_r.scfg.read_timing_select) begin
            st_nxt.mode = ARP_MODE_MST_RDD; // RL13
        end else begin
            st_nxt.mode = ARP_MODE_MST_RDC; // RL13
        end
        // pin drive
        if (!st_r.ctrl.port_type_select) begin
            st_nxt.pins.d_out = lanes; // RL1
            st_nxt.pins.d_oe = 16'hffff; // RL4 RL5
            st_nxt.pins.sclk_o = 1'b0;
            st_nxt.pins.sclk_oe = 1'b0;
            st_nxt.pins.strobe_o = 1'b0;
            st_nxt.pins.strobe_oe = 1'b0;
        end else begin
            st_nxt.pins.d_out = 16'h0000;
            st_nxt.pins.d_out[`ARP_SERIAL_RESULT_OUT_LANE] = ser_bit;
            // lanes 0..7 float or listen, divider pins included
            st_nxt.pins.d_oe = 16'h0000; // RL4 RL7
            st_nxt.pins.d_oe[`ARP_SERIAL_RESULT_OUT_LANE] = 1'b1;
            st_nxt.pins.sclk_oe = (st_r.mode != ARP_MODE_SLV); // RL8 RL9
            st_nxt.pins.sclk_o = (st_r.mode != ARP_MODE_SLV) && ser_sclk; // RL8
            st_nxt.pins.strobe_oe = 1'b1;
            st_nxt.pins.strobe_o = ser_frame ^ st_r.scfg.frame_strobe_polarity_select; // RL11
        end
        st_nxt.chk_hi = st_r.pins.sclk_o ? st_r.chk_hi + 8'h01 : 8'h00;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.awready <= 1'b1;
            st_r.wready <= 1'b1;
            st_r.arready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready  = st_r.wready;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;
    assign s_axi_rvalid  = st_r.rvalid;
    assign pins_o        = st_r.pins;

    // checks
    always_comb begin
        case (used_div)
            2'b00:   exp_hi = 8'((`ARP_CYC(`ARP_SCLK_NS_00) + 1) / 2);
            2'b01:   exp_hi = 8'((`ARP_CYC(`ARP_SCLK_NS_01) + 1) / 2);
            2'b10:   exp_hi = 8'((`ARP_CYC(`ARP_SCLK_NS_10) + 1) / 2);
            default: exp_hi = 8'((`ARP_CYC(`ARP_SCLK_NS_11) + 1) / 2);
        endcase
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_lanes_straight;
        $past(rst_n && !st_r.ctrl.port_type_select && !st_r.ctrl.byte_order_select)
            |-> st_r.pins.d_out == $past(coded);
    endproperty
    a_lanes_straight: assert property (p_lanes_straight) else $error("low byte lane wrong"); // RL1

    property p_lanes_swap;
        $past(!st_r.ctrl.port_type_select && st_r.ctrl.byte_order_select)
            |-> st_r.pins.d_out == {$past(coded[7:0]), $past(coded[15:8])};
    endproperty
    a_lanes_swap: assert property (p_lanes_swap) else $error("swapped lanes wrong"); // RL1

    property p_coding;
        conv_done ##1 !st_r.ctrl.output_coding_select
            |-> coded[BITS-1] == ~$past(conv_data[BITS-1]);
    endproperty
    a_coding: assert property (p_coding) else $error("msb not inverted"); // RL2

    property p_serial_lanes;
        $past(st_r.ctrl.port_type_select)
            |-> st_r.pins.d_oe == 16'h0100 && st_r.pins.strobe_oe;
    endproperty
    a_serial_lanes: assert property (p_serial_lanes) else $error("serial pin drive wrong"); // RL3

    property p_low_pins_float;
        $past(st_r.ctrl.port_type_select) |-> st_r.pins.d_oe[1:0] == 2'b00;
    endproperty
    a_low_pins_float: assert property (p_low_pins_float) else $error("D0 D1 driven"); // RL4

    property p_par_outputs;
        $past(rst_n && !st_r.ctrl.port_type_select)
            |-> &st_r.pins.d_oe[5:2] && !st_r.pins.sclk_oe;
    endproperty
    a_par_outputs: assert property (p_par_outputs) else $error("D2..D5 not driven"); // RL5

    property p_div_float;
        st_r.mode != ARP_MODE_PAR && $past(st_r.ctrl.port_type_select)
            |-> st_r.pins.d_oe[3:2] == 2'b00;
    endproperty
    a_div_float: assert property (p_div_float) else $error("divider pins driven"); // RL7

    property p_master_clock;
        $past(st_r.ctrl.port_type_select && st_r.mode == ARP_MODE_MST_RDC)
            |-> st_r.pins.sclk_oe;
    endproperty
    a_master_clock: assert property (p_master_clock) else $error("master not driving sclk"); // RL8

    property p_slave_gate;
        st_r.mode == ARP_MODE_SLV && cs_n && !ser_start ##1 st_r.mode == ARP_MODE_SLV && cs_n
            |=> $stable(st_r.pins.d_out[8]);
    endproperty
    a_slave_gate: assert property (p_slave_gate) else $error("slave moved without cs"); // RL10

    property p_strobe_pol;
        $past(st_r.ctrl.port_type_select)
            |-> st_r.pins.strobe_o == ($past(ser_frame)
                ^ $past(st_r.scfg.frame_strobe_polarity_select));
    endproperty
    a_strobe_pol: assert property (p_strobe_pol) else $error("strobe polarity wrong"); // RL11

    property p_sclk_high;
        $fell(st_r.pins.sclk_o) && $stable(used_div) |-> st_r.chk_hi == exp_hi;
    endproperty
    a_sclk_high: assert property (p_sclk_high) else $error("sclk high time wrong"); // RL6 RL12

    property p_read_during;
        st_r.mode == ARP_MODE_MST_RDD && conv_start && !ser_busy
            && st_r.ctrl.port_type_select
            |-> ##2 st_r.pins.strobe_o != st_r.scfg.frame_strobe_polarity_select;
    endproperty
    a_read_during: assert property (p_read_during) else $error("no frame during conversion"); // RL13

    c_par_swap: cover property (!st_r.ctrl.port_type_select && st_r.ctrl.byte_order_select);
    c_master_frame: cover property ($rose(ser_frame) && st_r.mode == ARP_MODE_MST_RDC);
    c_slave_shift: cover property (st_r.mode == ARP_MODE_SLV && $fell(ser_busy));
endmodule : arp_top
`default_nettype wire

// file: tb/arp_host.sv
// Purpose: far side host that clocks the slave serial port
// Assumes: go held until done rises
// Notes:   serial clock pulses three times before cs_n falls, then stands low after the frame
`timescale 1ns/10ps
`default_nettype none
module arp_host (
    input  wire logic        mclk,
    input  wire logic        go,
    input  wire logic        serial_result_out,
    output logic             cs_n,
    output logic             sclk_i,
    output logic [15:0]      got,
    output logic             done
);
    task tick;
        sclk_i <= 1;
        repeat (3) @(posedge mclk);
        sclk_i <= 0;
        repeat (3) @(posedge mclk);
    endtask : tick
    initial begin
        {cs_n, sclk_i, got, done} = {2'h2, 17'h0};
        forever begin
            @(posedge mclk);
            if (go && !done) begin
                repeat (3) tick();
                cs_n <= 0;
                repeat (2) @(posedge mclk);
                repeat (16) begin
                    got <= {got[14:0], serial_result_out};
                    tick();
                end
                cs_n <= 1;
                done <= 1;
            end
        end
    end
endmodule : arp_host
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: self-checking bench for arp_top
// Assumes: arp_host plays the slave-mode host
// Notes:   fixed seed, random results with corner words
`timescale 1ns/10ps
`default_nettype none
module tb_top import arp_pkg::*; ;
    logic mclk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, conv_start, conv_done, go, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, cs_n, sclk_i, done;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [15:0] conv_data, d_in, got, e, bits;
    arp_pins_type pins_o;
    int bad_count, checked, cyc, n, b, k;
    arp_top i_dut (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_start,
        .conv_done, .conv_data, .d_in, .cs_n, .sclk_i, .pins_o);
    arp_host i_host (.mclk, .go, .serial_result_out(pins_o.d_out[8]), .cs_n, .sclk_i, .got, .done);
    function automatic logic [15:0] fmt(logic [15:0] r, logic c, logic s);
        fmt = c ? r : r ^ 16'h8000;
        if (s) fmt = {fmt[7:0], fmt[15:8]};
    endfunction : fmt
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task conclude;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1);
        rs = s_axi_bresp;
        s_axi_bready <= 0;
    endtask : wr
    task rdr(input logic [11:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 0;
    endtask : rdr
    task conv(input logic [15:0] d);
        @(posedge mclk);
        {conv_data, conv_done} <= {d, 1'h1};
        @(posedge mclk);
        conv_done <= 0;
        repeat (3) @(posedge mclk);
    endtask : conv
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        mclk = 0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
        {s_axi_rready, conv_start, conv_done, go, d_in, conv_data} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cyc} = 0;
        s_axi_wstrb = 4'hf;
        void'($urandom(32'h2d13226a));
        repeat (6) @(posedge mclk);
        rst_n <= 1;
        rdr(12'h000);
        chk("ctrl", 32'h0, rd);
        rdr(12'h00c);
        chk("resp", 2'h2, rs);
        wr(12'h010, 32'h0);
        chk("bresp", 2'h2, rs);
        for (n = 0; n < 12; n++) begin
            e = (n < 4) ? {16{n[0]}} ^ 16'h7f80 : 16'($urandom);
            wr(12'h000, {29'h0, n[2:1], 1'h0});
            conv(e);
            chk("d_oe", 16'hffff, pins_o.d_oe);
            chk("d_out", fmt(e, n[2], n[1]), pins_o.d_out);
            rdr(12'h008);
            chk("result", fmt(e, n[2], 0), rd[15:0]);
        end
        wr(12'h000, 32'h5);
        for (n = 0; n < 5; n++) begin
            d_in <= {8'h0, n[2], 1'h0, n[0], 1'h0, 2'(n), 2'h0};
            e = 16'($urandom);
            repeat (24) @(posedge mclk);
            conv(e);
            // n = 4 reads during: held result leaves on conversion start
            if (n[2]) begin
                conv_start <= 1;
                @(posedge mclk);
                conv_start <= 0;
            end
            for (b = 0; b < 16; b++) begin
                k = 0;
                while (pins_o.sclk_o !== 1) begin @(posedge mclk); k++; end
                if (b == 0) chk("strobe", !n[0], pins_o.strobe_o);
                while (pins_o.sclk_o !== 0) begin @(posedge mclk); k++; end
                bits = {bits[14:0], pins_o.d_out[8]};
                if (b > 0) chk("period", 5 << n[1:0], k);
            end
            chk("sd_oe", 16'h0100, pins_o.d_oe);
            chk("sclk_oe", 1, pins_o.sclk_oe);
            chk("master", e, bits);
        end
        d_in <= 16'h0010;
        e = 16'($urandom);
        repeat (24) @(posedge mclk);
        conv(e);
        chk("slv_oe", 3'h0, {pins_o.sclk_oe, pins_o.d_oe[3:2]});
        go <= 1;
        while (done !== 1) @(posedge mclk);
        go <= 0;
        chk("slave", e, got);
        rdr(12'h004);
        chk("stat", 32'h13, rd);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
